// ### src/npm_regs.vh
/*
  Constants of the poll activation and frame mapper: register offsets,
  field positions, codes and buffer layout.
  Assumes inclusion by the framer and mapper design files; the memory module does not include it.
*/
`ifndef NPM_REGS_VH
`define NPM_REGS_VH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define NPM_A_CTRL 4'h0
`define NPM_A_BITRATE 4'h1
`define NPM_A_CMD 4'h2
`define NPM_A_STATUS 4'h3
`define NPM_A_NOTICE 4'h4
`define NPM_A_TXDATA 4'h5
`define NPM_A_RXPTR 4'h6
`define NPM_A_RXDATA 4'h7
`define NPM_A_RXLEN 4'h8
`define NPM_A_ACTBASE 4'h9
`define NPM_A_ACTLEN 4'ha
`define NPM_A_STATE 4'hb

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define NPM_CTRL_POLL_A 0
`define NPM_CTRL_POLL_B 1
`define NPM_CTRL_POLL_V 2
`define NPM_CMD_SELECT 0
`define NPM_CMD_DEACT 1
`define NPM_CMD_TXGO 2
`define NPM_CMD_START 3
`define NPM_CMD_TAG 4
`define NPM_REQ_OPTION_BIT 7

// ------------------------------------------------------------
// codes
// ------------------------------------------------------------
`define NPM_RATE_106 2'h0
`define NPM_RATE_MAX 8'h03
`define NPM_ST_OK 8'h00
`define NPM_ST_CORRUPTED 8'h02
`define NPM_RF_RATS 2'h1
`define NPM_RF_PPS 2'h2
`define NPM_RF_INVENTORY 2'h3
`define NPM_TECH_A 2'h0
`define NPM_TECH_B 2'h1
`define NPM_NTF_ACTIVATED 2'h1
`define NPM_NTF_FOUND 2'h2

// ------------------------------------------------------------
// receive buffer layout
// ------------------------------------------------------------
`define NPM_RX_BASE 6'h20
`define NPM_RX_CAP 5'h1e
`define NPM_INV_LEN 5'h0a
`define NPM_MAX_TAGS 2'h2

`endif

// ### src/npm_mem.v
/*
  Small byte memory: one write port, one read port, read data registered.
  Assumes the user presents the read address one cycle ahead.
*/
`timescale 1ns/1ps
module npm_mem (
  clk, // clock
  we, // write enable
  wa, // write address
  wd, // write data
  ra, // read address
  rd // read data, one cycle after ra
);
  input wire clk;
  input wire we;
  input wire [5:0] wa;
  input wire [7:0] wd;
  input wire [5:0] ra;
  output reg [7:0] rd;

  reg [7:0] mem [0:63];

  always @(posedge clk) begin
    if (we) begin
      mem[wa] <= wd;
    end
    rd <= mem[ra];
  end
endmodule // npm_mem

// ### src/npm_tx_framer.v
/*
  Sends one stored host message as an RF frame: start of frame, the data
  bytes with end-of-data on the last, then end of frame.
  Assumes the byte store answers one cycle after the address.
*/
`timescale 1ns/1ps
`include "npm_regs.vh"
module npm_tx_framer (
  clk, // clock
  rst_n, // synchronous copy of reset, low active
  start, // begin a frame
  len, // number of data bytes
  special_en, // option flag may select vendor mode
  mem_addr, // byte store address
  mem_data, // byte store data
  busy, // frame in progress
  tx_valid, // data byte valid
  tx_data, // data byte
  tx_sof, // start of frame pulse
  tx_eof, // end of frame pulse
  tx_eod, // marks the last data byte
  tx_special // vendor mode for this frame
);
  input wire clk;
  input wire rst_n;
  input wire start;
  input wire [5:0] len;
  input wire special_en;
  output wire [5:0] mem_addr;
  input wire [7:0] mem_data;
  output wire busy;
  output reg tx_valid;
  output reg [7:0] tx_data;
  output reg tx_sof;
  output reg tx_eof;
  output reg tx_eod;
  output reg tx_special;

  localparam S_IDLE = 4'b0001;
  localparam S_SOF = 4'b0010;
  localparam S_DATA = 4'b0100;
  localparam S_EOF = 4'b1000;

  reg [3:0] state_reg;
  reg [5:0] idx_reg;
  reg [5:0] len_reg;

  assign mem_addr = idx_reg;
  assign busy = (state_reg != S_IDLE);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= S_IDLE;
      idx_reg <= 6'h00;
      len_reg <= 6'h00;
      tx_valid <= 1'b0;
      tx_data <= 8'h00;
      tx_sof <= 1'b0;
      tx_eof <= 1'b0;
      tx_eod <= 1'b0;
      tx_special <= 1'b0;
    end else begin
      tx_valid <= 1'b0;
      tx_sof <= 1'b0;
      tx_eof <= 1'b0;
      tx_eod <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          tx_special <= 1'b0;
          idx_reg <= 6'h00;
          if (start) begin
            len_reg <= len;
            state_reg <= S_SOF;
          end
        end
        S_SOF: begin
          tx_sof <= 1'b1;
          idx_reg <= 6'h01;
          state_reg <= (len_reg == 6'h00) ? S_EOF : S_DATA;
        end
        S_DATA: begin
          tx_valid <= 1'b1;
          tx_data <= mem_data;
          if (idx_reg == 6'h01) begin
            tx_special <= special_en &
              mem_data[`NPM_REQ_OPTION_BIT];
          end
          if (idx_reg == len_reg) begin
            tx_eod <= 1'b1;
            state_reg <= S_EOF;
          end
          idx_reg <= idx_reg + 6'h01;
        end
        S_EOF: begin
          tx_eof <= 1'b1;
          state_reg <= S_IDLE;
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end
endmodule // npm_tx_framer

// ### src/npm_mapper.v
/*
  Poll-side activation and frame mapping of a contactless controller:
  type A/B ISO-DEP activation with optional rate change for type A, vicinity tag
  discovery of up to two tags, frame transmit and receive mapping.
  Assumes a host on a plain register port and an RF engine that frames
  bits, reports found targets and raises one byte per cycle at most.
*/
`timescale 1ns/1ps
`include "npm_regs.vh"

// Notes on behaviour
// - rates 106, 212, 424 and 848 kb/s selectable for type A; type B stays at 106 kb/s
// - activation always runs at 106 kb/s, the default rate
// - type A with ISO-DEP after anticollision: send RATS, await answer
// - rate change exchange only if poll_bit_rate_setting allowed above 0
// - type A activated notice only after target answered activation command; type B notice at once on find
// - type A activated notice reports the rate really used on RF
// - type A parameters: length n then RATS answer from byte two
// - vicinity parameters: flags, family_identifier, 8 byte identifier
// - vicinity tags map to frame interface without mapping command
// - each host message is sent framed with EoD, SOF and EOF
// - bytes pass unchanged; request option bit b7 selects vendor mode
// - received frame stripped of framing, payload then status byte
// - on error payload may be partial, status byte always present
// - status is ok code or frame_corrupted_code on reception error
// - vicinity collisions resolved by inventory, two tags at most
// - two tags: wait all found, notice first, wait until read; notice second, wait pick
// - target select activates frame interface at once, no checks
// - poll active: host data sent; absent tag yields no reply
module npm_mapper (
  CLK, // clock, 250 MHz
  NRST, // reset, low active
  ADDR, // register address
  WDATA, // register write data
  WR, // write strobe
  RD, // read strobe
  RDATA, // read data, cycle after RD
  RF_POLL_EN, // poll modes enabled: A, B, vicinity
  RF_CMD_VALID, // RF command pulse
  RF_CMD_CODE, // RATS, rate change or inventory
  RF_CMD_ARG, // rate for the rate change command
  RF_RATE, // rate in use on RF
  RF_FOUND, // A or B target found after anticollision
  RF_TECH, // technology of the found target
  RF_ISODEP, // found target supports ISO-DEP
  RF_INV_DONE, // inventory round finished
  RF_RX_SOF, // receive start of frame
  RF_RX_VALID, // receive byte valid
  RF_RX_DATA, // receive byte
  RF_RX_EOF, // receive end of frame
  RF_RX_ERR, // framing or check fault, with RF_RX_EOF
  RF_TX_VALID, // transmit byte valid
  RF_TX_DATA, // transmit byte
  RF_TX_SOF, // transmit start of frame
  RF_TX_EOF, // transmit end of frame
  RF_TX_EOD, // last transmit data byte
  RF_TX_SPECIAL // vendor mode for this frame
);
  input wire CLK;
  input wire NRST;
  input wire [3:0] ADDR;
  input wire [7:0] WDATA;
  input wire WR;
  input wire RD;
  output reg [7:0] RDATA;
  output wire [2:0] RF_POLL_EN;
  output reg RF_CMD_VALID;
  output reg [1:0] RF_CMD_CODE;
  output reg [1:0] RF_CMD_ARG;
  output wire [1:0] RF_RATE;
  input wire RF_FOUND;
  input wire [1:0] RF_TECH;
  input wire RF_ISODEP;
  input wire RF_INV_DONE;
  input wire RF_RX_SOF;
  input wire RF_RX_VALID;
  input wire [7:0] RF_RX_DATA;
  input wire RF_RX_EOF;
  input wire RF_RX_ERR;
  output wire RF_TX_VALID;
  output wire [7:0] RF_TX_DATA;
  output wire RF_TX_SOF;
  output wire RF_TX_EOF;
  output wire RF_TX_EOD;
  output wire RF_TX_SPECIAL;

  // ------------------------------------------------------------
  // states
  // ------------------------------------------------------------
  localparam S_IDLE = 7'b0000001;
  localparam S_DISC = 7'b0000010;
  localparam S_RATS = 7'b0000100;
  localparam S_PPS = 7'b0001000;
  localparam S_WALL = 7'b0010000;
  localparam S_WPICK = 7'b0100000;
  localparam S_ACTIVE = 7'b1000000;

  // ------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------
  reg rst_meta_reg;
  reg rst_n;
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      rst_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n <= rst_meta_reg;
    end
  end

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  reg [6:0] state_reg, state_next;
  reg [2:0] ctrl_reg;
  reg [7:0] bitrate_reg;
  reg [1:0] rate_reg, rate_next;
  reg [1:0] tag_cnt_reg;
  reg [7:0] notice_reg;
  reg [5:0] act_base_reg, act_base_next;
  reg [5:0] act_len_reg, act_len_next;
  reg act_frame_reg;
  reg ntf_set;
  reg [7:0] ntf_val;
  reg cmd_set;
  reg [1:0] cmd_code;
  reg rx_open_reg, rx_first_reg, rx_err_reg, rx_done_reg;
  reg [4:0] rx_cnt_reg;
  reg [5:0] rx_len_reg;
  reg [5:0] rx_ptr_reg, rx_ptr_next;
  reg [5:0] tx_wcnt_reg;
  reg tx_start;

  wire wr_cmd = WR && (ADDR == `NPM_A_CMD);
  wire go_start = wr_cmd && WDATA[`NPM_CMD_START];
  wire go_sel = wr_cmd && WDATA[`NPM_CMD_SELECT];
  wire go_deact = wr_cmd && WDATA[`NPM_CMD_DEACT];
  wire go_tx = wr_cmd && WDATA[`NPM_CMD_TXGO];
  wire pick_tag = WDATA[`NPM_CMD_TAG];
  wire st_disc = (state_reg == S_DISC);
  wire st_rats = (state_reg == S_RATS);
  wire st_active = (state_reg == S_ACTIVE);
  wire rd_notice = RD && (ADDR == `NPM_A_NOTICE);
  wire rd_rxlen = RD && (ADDR == `NPM_A_RXLEN);
  wire rd_rxdata = RD && (ADDR == `NPM_A_RXDATA);
  wire rate_ok = (bitrate_reg != 8'h00) &&
                 (bitrate_reg <= `NPM_RATE_MAX);
  wire tx_busy;
  wire [7:0] rx_rd;
  wire [7:0] tx_rd;
  wire [5:0] tx_ra;

  // ------------------------------------------------------------
  // receive path
  // ------------------------------------------------------------
  wire rx_end = RF_RX_EOF && rx_open_reg;
  wire rx_full = st_disc ? (rx_cnt_reg == `NPM_INV_LEN)
                         : (rx_cnt_reg == `NPM_RX_CAP);
  wire rx_byte = RF_RX_VALID && rx_open_reg && !RF_RX_EOF &&
                 !(st_rats && rx_first_reg);
  // the rate change answer must not overwrite the stored RATS parameters
  wire rx_store = rx_byte && !rx_full && (state_reg != S_PPS) &&
                  !(st_disc && tag_cnt_reg == `NPM_MAX_TAGS);
  wire rx_bad = rx_err_reg || RF_RX_ERR || (rx_byte && rx_full);
  wire [7:0] rx_status = rx_bad ? `NPM_ST_CORRUPTED
                                : `NPM_ST_OK;
  wire eof_wr = rx_end && (st_active || st_rats);
  wire [5:0] rx_off = {1'b0, rx_cnt_reg};
  wire [5:0] rx_wa = eof_wr ? (st_rats ? `NPM_RX_BASE
                                       : `NPM_RX_BASE + rx_off)
                   : st_disc ? {1'b0, tag_cnt_reg[0], rx_cnt_reg[3:0]}
                   : st_rats ? `NPM_RX_BASE + 6'h01 + rx_off
                   : `NPM_RX_BASE + rx_off;
  wire [7:0] rx_wd = eof_wr ? (st_rats ? {3'h0, rx_cnt_reg}
                                       : rx_status)
                   : RF_RX_DATA;

  always @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      rx_open_reg <= 1'b0;
      rx_first_reg <= 1'b0;
      rx_err_reg <= 1'b0;
      rx_cnt_reg <= 5'h00;
    end else if (RF_RX_SOF) begin
      rx_open_reg <= 1'b1;
      rx_first_reg <= 1'b1;
      rx_err_reg <= 1'b0;
      rx_cnt_reg <= 5'h00;
    end else if (rx_end) begin
      rx_open_reg <= 1'b0;
    end else if (RF_RX_VALID && rx_open_reg) begin
      rx_first_reg <= 1'b0;
      if (rx_byte && rx_full) begin
        rx_err_reg <= 1'b1;
      end
      if (rx_store) begin
        rx_cnt_reg <= rx_cnt_reg + 5'h01;
      end
    end
  end

  npm_mem u_rx_mem (
    .clk(CLK),
    .we(eof_wr || rx_store),
    .wa(rx_wa),
    .wd(rx_wd),
    .ra(rx_ptr_next),
    .rd(rx_rd)
  );

  // ------------------------------------------------------------
  // control sequence
  // ------------------------------------------------------------
  always @* begin
    state_next = state_reg;
    rate_next = rate_reg;
    act_base_next = act_base_reg;
    act_len_next = act_len_reg;
    ntf_set = 1'b0;
    ntf_val = 8'h00;
    cmd_set = 1'b0;
    cmd_code = `NPM_RF_RATS;
    tx_start = 1'b0;
    case (state_reg)
      S_IDLE: begin
        rate_next = `NPM_RATE_106;
        if (go_start && ctrl_reg != 3'h0) begin
          state_next = S_DISC;
          cmd_set = ctrl_reg[`NPM_CTRL_POLL_V];
          cmd_code = `NPM_RF_INVENTORY;
        end
      end
      S_DISC: begin
        if (RF_FOUND && RF_ISODEP && RF_TECH == `NPM_TECH_A) begin
          state_next = S_RATS;
          cmd_set = 1'b1;
          cmd_code = `NPM_RF_RATS;
        end else if (RF_FOUND && RF_ISODEP &&
                     RF_TECH == `NPM_TECH_B) begin
          state_next = S_ACTIVE;
          act_base_next = `NPM_RX_BASE;
          act_len_next = 6'h00;
          ntf_set = 1'b1;
          ntf_val = {2'b00, rate_reg, 2'b00, `NPM_NTF_ACTIVATED};
        end else if (RF_INV_DONE && tag_cnt_reg == `NPM_MAX_TAGS) begin
          state_next = S_WALL;
          ntf_set = 1'b1;
          ntf_val = {6'h00, `NPM_NTF_FOUND};
        end else if (RF_INV_DONE && tag_cnt_reg != 2'h0) begin
          state_next = S_ACTIVE;
          act_base_next = 6'h00;
          act_len_next = {1'b0, `NPM_INV_LEN};
          ntf_set = 1'b1;
          ntf_val = {2'b01, rate_reg, 2'b00, `NPM_NTF_ACTIVATED};
        end else if (RF_INV_DONE) begin
          cmd_set = 1'b1;
          cmd_code = `NPM_RF_INVENTORY;
        end
      end
      S_RATS: begin
        if (rx_end && rate_ok) begin
          state_next = S_PPS;
          cmd_set = 1'b1;
          cmd_code = `NPM_RF_PPS;
        end else if (rx_end) begin
          state_next = S_ACTIVE;
          act_base_next = `NPM_RX_BASE;
          act_len_next = {1'b0, rx_cnt_reg} + 6'h01;
          ntf_set = 1'b1;
          ntf_val = {2'b00, rate_reg, 2'b00, `NPM_NTF_ACTIVATED};
        end
      end
      S_PPS: begin
        if (rx_end) begin
          state_next = S_ACTIVE;
          rate_next = bitrate_reg[1:0];
          act_base_next = `NPM_RX_BASE;
          ntf_set = 1'b1;
          ntf_val = {2'b00, bitrate_reg[1:0], 2'b00,
                     `NPM_NTF_ACTIVATED};
        end
      end
      S_WALL: begin
        if (!notice_reg[7]) begin
          state_next = S_WPICK;
          ntf_set = 1'b1;
          ntf_val = {5'h00, 1'b1, `NPM_NTF_FOUND};
        end
      end
      S_WPICK: begin
        if (go_sel) begin
          state_next = S_ACTIVE;
          act_base_next = {1'b0, pick_tag, 4'h0};
          act_len_next = {1'b0, `NPM_INV_LEN};
          ntf_set = 1'b1;
          ntf_val = {2'b01, rate_reg, 1'b0, pick_tag,
                     `NPM_NTF_ACTIVATED};
        end
      end
      S_ACTIVE: begin
        tx_start = go_tx && !tx_busy;
      end
      default: begin
        state_next = S_IDLE;
      end
    endcase
    if (go_deact) begin
      state_next = S_IDLE;
      rate_next = `NPM_RATE_106;
    end
  end

  always @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= S_IDLE;
      rate_reg <= `NPM_RATE_106;
      act_base_reg <= 6'h00;
      act_len_reg <= 6'h00;
      act_frame_reg <= 1'b0;
      notice_reg <= 8'h00;
      tag_cnt_reg <= 2'h0;
      RF_CMD_VALID <= 1'b0;
      RF_CMD_CODE <= 2'h0;
      RF_CMD_ARG <= 2'h0;
    end else begin
      state_reg <= state_next;
      rate_reg <= rate_next;
      act_base_reg <= act_base_next;
      act_len_reg <= (st_rats && rx_end) ?
                     {1'b0, rx_cnt_reg} + 6'h01 : act_len_next;
      RF_CMD_VALID <= cmd_set;
      if (cmd_set) begin
        RF_CMD_CODE <= cmd_code;
        RF_CMD_ARG <= bitrate_reg[1:0];
      end
      if (ntf_set) begin
        notice_reg <= {1'b1, ntf_val[6:0]}; // set wins over clear
        act_frame_reg <= ntf_val[6];
      end else if (rd_notice) begin
        notice_reg <= {1'b0, notice_reg[6:0]};
      end
      if (state_reg == S_IDLE) begin
        tag_cnt_reg <= 2'h0;
      end else if (st_disc && rx_end && !rx_bad &&
                   rx_cnt_reg == `NPM_INV_LEN &&
                   tag_cnt_reg != `NPM_MAX_TAGS) begin
        tag_cnt_reg <= tag_cnt_reg + 2'h1;
      end
    end
  end

  assign RF_POLL_EN = st_disc ? ctrl_reg : 3'h0;
  assign RF_RATE = rate_reg;

  // ------------------------------------------------------------
  // transmit path
  // ------------------------------------------------------------
  npm_mem u_tx_mem (
    .clk(CLK),
    .we(WR && ADDR == `NPM_A_TXDATA && !tx_busy),
    .wa(tx_wcnt_reg),
    .wd(WDATA),
    .ra(tx_ra),
    .rd(tx_rd)
  );

  npm_tx_framer u_framer (
    .clk(CLK),
    .rst_n(rst_n),
    .start(tx_start),
    .len(tx_wcnt_reg),
    .special_en(act_frame_reg),
    .mem_addr(tx_ra),
    .mem_data(tx_rd),
    .busy(tx_busy),
    .tx_valid(RF_TX_VALID),
    .tx_data(RF_TX_DATA),
    .tx_sof(RF_TX_SOF),
    .tx_eof(RF_TX_EOF),
    .tx_eod(RF_TX_EOD),
    .tx_special(RF_TX_SPECIAL)
  );

  // ------------------------------------------------------------
  // register port
  // ------------------------------------------------------------
  always @* begin
    rx_ptr_next = rx_ptr_reg;
    if (WR && ADDR == `NPM_A_RXPTR) begin
      rx_ptr_next = WDATA[5:0];
    end else if (rd_rxdata) begin
      rx_ptr_next = rx_ptr_reg + 6'h01;
    end
  end

  always @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= 3'h0;
      bitrate_reg <= 8'h00;
      rx_ptr_reg <= 6'h00;
      tx_wcnt_reg <= 6'h00;
      rx_len_reg <= 6'h00;
      rx_done_reg <= 1'b0;
      RDATA <= 8'h00;
    end else begin
      rx_ptr_reg <= rx_ptr_next;
      if (WR && ADDR == `NPM_A_CTRL) begin
        ctrl_reg <= WDATA[2:0];
      end
      if (WR && ADDR == `NPM_A_BITRATE) begin
        bitrate_reg <= WDATA;
      end
      if (tx_start) begin
        tx_wcnt_reg <= 6'h00;
      end else if (WR && ADDR == `NPM_A_TXDATA && !tx_busy &&
                   tx_wcnt_reg != 6'h3f) begin
        tx_wcnt_reg <= tx_wcnt_reg + 6'h01;
      end
      if (eof_wr && st_active) begin
        rx_len_reg <= {1'b0, rx_cnt_reg} + 6'h01;
        rx_done_reg <= 1'b1;
      end else if (rd_rxlen) begin
        rx_done_reg <= 1'b0;
      end
      case (ADDR)
        `NPM_A_CTRL: RDATA <= {5'h00, ctrl_reg};
        `NPM_A_BITRATE: RDATA <= bitrate_reg;
        `NPM_A_STATUS: RDATA <= {2'b00, rate_reg, tag_cnt_reg,
                                 rx_done_reg, tx_busy};
        `NPM_A_NOTICE: RDATA <= notice_reg;
        `NPM_A_RXPTR: RDATA <= {2'b00, rx_ptr_reg};
        `NPM_A_RXDATA: RDATA <= rx_rd;
        `NPM_A_RXLEN: RDATA <= {2'b00, rx_len_reg};
        `NPM_A_ACTBASE: RDATA <= {2'b00, act_base_reg};
        `NPM_A_ACTLEN: RDATA <= {2'b00, act_len_reg};
        `NPM_A_STATE: RDATA <= {1'b0, state_reg};
        default: RDATA <= 8'h00;
      endcase
    end
  end
endmodule // npm_mapper

// ### tb/npm_mapper_assertions.sv
/* port checker of the mapper
   bound to npm_mapper, sees only its ports */
`timescale 1ns/1ps
module npm_mapper_chk (
  input wire CLK, // clock
  input wire NRST, // reset, low active
  input wire [2:0] RF_POLL_EN, // poll enables
  input wire RF_CMD_VALID, // rf command
  input wire [1:0] RF_CMD_CODE, // command code
  input wire [1:0] RF_CMD_ARG, // rate argument
  input wire [1:0] RF_RATE, // rate in use
  input wire RF_FOUND, // target found
  input wire [1:0] RF_TECH, // technology
  input wire RF_ISODEP, // iso-dep able
  input wire RF_TX_VALID, // tx byte
  input wire RF_TX_SOF, // tx start
  input wire RF_TX_EOF, // tx end
  input wire RF_TX_EOD // tx last byte
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  rats_follow_a: assert property (
    RF_FOUND && RF_POLL_EN[0] && RF_TECH == 2'h0 && RF_ISODEP
    |=> RF_CMD_VALID && RF_CMD_CODE == 2'h1) else $error("no rats");
  pps_rate_a: assert property (
    RF_CMD_VALID && RF_CMD_CODE == 2'h2 |-> RF_CMD_ARG != 2'h0)
    else $error("rate change to default");
  rats_slow_a: assert property (
    RF_CMD_VALID && RF_CMD_CODE == 2'h1 |-> RF_RATE == 2'h0)
    else $error("rats above default rate");
  rate_report_a: assert property (
    $changed(RF_RATE) && RF_RATE != 2'h0 |-> RF_RATE == RF_CMD_ARG)
    else $error("rate differs from request");
  inventory_start_a: assert property (
    $rose(RF_POLL_EN[2]) |-> ##[0:1] RF_CMD_VALID && RF_CMD_CODE == 2'h3)
    else $error("no inventory");
  eod_eof_a: assert property (
    RF_TX_EOD |=> RF_TX_EOF && !RF_TX_VALID) else $error("no end");
  eod_valid_a: assert property (
    RF_TX_EOD |-> RF_TX_VALID) else $error("eod without byte");
  sof_next_a: assert property (
    RF_TX_SOF |=> RF_TX_VALID || RF_TX_EOF) else $error("gap after sof");
endmodule // npm_mapper_chk
bind npm_mapper npm_mapper_chk u_chk (.CLK, .NRST, .RF_POLL_EN,
  .RF_CMD_VALID, .RF_CMD_CODE, .RF_CMD_ARG, .RF_RATE, .RF_FOUND,
  .RF_TECH, .RF_ISODEP, .RF_TX_VALID, .RF_TX_SOF, .RF_TX_EOF, .RF_TX_EOD);

// ### tb/npm_rf_model.sv
/* rf engine stand-in: finds targets, answers commands and frames
   driven by the mapper rf outputs; knobs set by the bench */
`timescale 1ns/1ps
module npm_rf_model (
  input wire clk, // clock
  input wire cmd_valid, // rf command
  input wire [1:0] cmd_code, // command code
  input wire tx_eof, // sent frame over
  output logic found, // target found
  output logic [1:0] tech, // technology
  output logic isodep, // iso-dep able
  output logic inv_done, // inventory over
  output logic sof, // rx start
  output logic valid, // rx byte valid
  output logic [7:0] data, // rx byte
  output logic eof, // rx end
  output logic err // rx fault
);
  int gap = 0, ntags = 0;
  bit bad = 0, mute = 0;
  initial {found, tech, isodep, inv_done, sof, valid, data, eof, err} = 0;
  task frame(input int n, input bit e);
    repeat (gap + 1) @(posedge clk);
    sof <= 1;
    for (int i = 0; i < n; i++) begin
      @(posedge clk) begin sof <= 0; valid <= 1; data <= 8'h40 + 8'(i); end
    end
    @(posedge clk) begin sof <= 0; valid <= 0; data <= ~data; eof <= 1;
      err <= e; end
    @(posedge clk) begin eof <= 0; err <= 0; end
  endtask
  task hit(input [1:0] t);
    @(posedge clk) begin found <= 1; tech <= t; isodep <= 1; end
    @(posedge clk) begin found <= 0; tech <= ~t; isodep <= 0; end
  endtask
  always @(posedge clk) begin
    if (cmd_valid && cmd_code == 2'h3) begin
      repeat (ntags) frame(10, 1'b0);
      @(posedge clk) inv_done <= 1;
      @(posedge clk) inv_done <= 0;
    end else if (cmd_valid) frame(cmd_code == 2'h1 ? 5 : 1, 1'b0);
    else if (tx_eof && !mute) frame(3, bad);
  end
endmodule // npm_rf_model

// ### tb/test_npm_mapper.sv
/* self-checking bench of the mapper
   rf side played by npm_rf_model */
`timescale 1ns/1ps
`include "npm_regs.vh"
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin fails++; \
  $display("unexpected at %0t: got %h want %h", $time, a, e); end end
module test_npm_mapper;
  logic CLK = 0, NRST = 0, WR = 0, RD = 0;
  logic [3:0] ADDR = 0;
  logic [7:0] WDATA = 0, RDATA, d, n, r;
  logic [2:0] RF_POLL_EN;
  logic RF_CMD_VALID, RF_FOUND, RF_ISODEP, RF_INV_DONE, RF_RX_SOF;
  logic RF_RX_VALID, RF_RX_EOF, RF_RX_ERR, RF_TX_VALID, RF_TX_SOF;
  logic RF_TX_EOF, RF_TX_EOD, RF_TX_SPECIAL;
  logic [1:0] RF_CMD_CODE, RF_CMD_ARG, RF_RATE, RF_TECH;
  logic [7:0] RF_RX_DATA, RF_TX_DATA;
  logic [7:0] txq[$], expq[$];
  int fails = 0, check_count = 0;
  bit spec;
  always #2 CLK = ~CLK;
  npm_mapper dut (.CLK, .NRST, .ADDR, .WDATA, .WR, .RD, .RDATA,
    .RF_POLL_EN, .RF_CMD_VALID, .RF_CMD_CODE, .RF_CMD_ARG, .RF_RATE,
    .RF_FOUND, .RF_TECH, .RF_ISODEP, .RF_INV_DONE, .RF_RX_SOF,
    .RF_RX_VALID, .RF_RX_DATA, .RF_RX_EOF, .RF_RX_ERR, .RF_TX_VALID,
    .RF_TX_DATA, .RF_TX_SOF, .RF_TX_EOF, .RF_TX_EOD, .RF_TX_SPECIAL);
  npm_rf_model rf (.clk(CLK), .cmd_valid(RF_CMD_VALID),
    .cmd_code(RF_CMD_CODE), .tx_eof(RF_TX_EOF), .found(RF_FOUND),
    .tech(RF_TECH), .isodep(RF_ISODEP), .inv_done(RF_INV_DONE),
    .sof(RF_RX_SOF), .valid(RF_RX_VALID), .data(RF_RX_DATA),
    .eof(RF_RX_EOF), .err(RF_RX_ERR));
  always @(posedge CLK) begin
    if (RF_TX_VALID) txq.push_back(RF_TX_DATA);
    if (RF_TX_SPECIAL) spec = 1;
  end
  task final_report;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task wr(input [3:0] a, input [7:0] v);
    @(posedge CLK) begin WR <= 1; ADDR <= a; WDATA <= v; end
    @(posedge CLK) WR <= 0;
  endtask
  task rd(input [3:0] a, output [7:0] v);
    @(posedge CLK) begin RD <= 1; ADDR <= a; end
    @(posedge CLK) RD <= 0;
    #1 v = RDATA;
  endtask
  task poll(input [3:0] a, input [7:0] m, output [7:0] v);
    v = 0;
    for (int i = 0; i < 300 && (v & m) == 0; i++) rd(a, v);
    if ((v & m) == 0) begin fails++; final_report(); end
  endtask
  task send(input int k, input bit hi);
    expq = {};
    for (int i = 0; i < k; i++) begin
      d = $urandom;
      d[7] = (i == 0) && hi;
      expq.push_back(d);
      wr(`NPM_A_TXDATA, d);
    end
    txq = {};
    spec = 0;
    wr(`NPM_A_CMD, 8'h04);
  endtask
  initial begin
    r = $urandom(32'h807b);
    repeat (2) @(posedge CLK);
    NRST <= 1;
    repeat (3) @(posedge CLK);
    // ---- type a with and without rate change, then type b ----
    rf.gap = $urandom % 3;
    for (int p = 0; p < 2; p++) begin
      r = p ? 8'h00 : 8'(1 + $urandom % 3);
      wr(`NPM_A_BITRATE, r);
      wr(`NPM_A_CTRL, 8'h03);
      wr(`NPM_A_CMD, 8'h08);
      rf.hit(2'h0);
      poll(`NPM_A_NOTICE, 8'h80, d);
      `CHK(d, 8'h81 | (r << 4))
      `CHK(RF_RATE, r[1:0])
      rd(`NPM_A_ACTBASE, d);
      wr(`NPM_A_RXPTR, d);
      rd(`NPM_A_RXDATA, n);
      `CHK(n, 8'h04)
      rd(`NPM_A_RXDATA, n);
      `CHK(n, 8'h41)
      wr(`NPM_A_CMD, 8'h02);
      rd(`NPM_A_STATUS, d);
      `CHK(d[5:4], 2'h0)
    end
    wr(`NPM_A_CTRL, 8'h02);
    wr(`NPM_A_CMD, 8'h08);
    rf.hit(2'h1);
    poll(`NPM_A_NOTICE, 8'h80, d);
    `CHK(d, 8'h81)
    wr(`NPM_A_CMD, 8'h02);
    // ---- two vicinity tags, select, frames ----
    rf.ntags = 2;
    wr(`NPM_A_CTRL, 8'h04);
    wr(`NPM_A_CMD, 8'h08);
    poll(`NPM_A_NOTICE, 8'h80, d);
    `CHK(d & 8'h8f, 8'h82)
    poll(`NPM_A_NOTICE, 8'h80, d);
    `CHK(d & 8'h8f, 8'h86)
    rd(`NPM_A_STATE, d);
    `CHK(d, 8'h20)
    wr(`NPM_A_CMD, 8'h11);
    rd(`NPM_A_STATE, d);
    `CHK(d, 8'h40)
    rd(`NPM_A_ACTBASE, d);
    wr(`NPM_A_RXPTR, d);
    for (int i = 0; i < 10; i++) rd(`NPM_A_RXDATA, n);
    `CHK(n, 8'h49)
    send(4, 1);
    poll(`NPM_A_STATUS, 8'h02, d);
    `CHK(txq == expq, 1'b1)
    `CHK(spec, 1'b1)
    rd(`NPM_A_RXLEN, n);
    `CHK(n, 8'h04)
    wr(`NPM_A_RXPTR, 8'h20);
    for (int i = 0; i < 4; i++) begin
      rd(`NPM_A_RXDATA, d);
      `CHK(d, i < 3 ? 8'h40 + 8'(i) : 8'h00)
    end
    rf.bad = 1;
    send(2, 0);
    poll(`NPM_A_STATUS, 8'h02, d);
    `CHK(spec, 1'b0)
    rd(`NPM_A_RXLEN, n);
    wr(`NPM_A_RXPTR, 8'h1f + n);
    rd(`NPM_A_RXDATA, d);
    `CHK(d, 8'h02)
    rf.mute = 1;
    send(1, 0);
    repeat (100) @(posedge CLK);
    rd(`NPM_A_STATUS, d);
    `CHK(d[1], 1'b0)
    wr(`NPM_A_CMD, 8'h02);
    rd(`NPM_A_STATE, d);
    `CHK(d, 8'h01)
    final_report();
  end
endmodule // test_npm_mapper
